// *** verilog/nvm_pkg.sv ***
// Constants and carriers for the nonvolatile word store programming port.
// Assumes an external I2C transport that presents decoded register reads and writes.
package nvm_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned WORDS = 24;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned REG_ADDR_W = 8;
   localparam logic [7:0] OFF_CONTROL = 8'hA1;
   localparam logic [7:0] OFF_SELECT = 8'hA2;
   localparam logic [7:0] OFF_VALUE = 8'hA3;
   // Control field positions
   localparam int unsigned BIT_VOLTAGE = 0;
   localparam int unsigned BIT_CLEAR = 1;
   localparam int unsigned BIT_WRITE = 2;
   localparam int unsigned BIT_READ = 3;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] SELECT_RESET = 16'h0000;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [15:0] WORD_RESET = 16'hFFFF;
   // Array cell time
   localparam int unsigned CLOCK_HZ = 10_000_000;
   localparam int unsigned CELL_TIME_MS = 10;
   localparam int unsigned CELL_CYCLES = CLOCK_HZ / 1000 * CELL_TIME_MS;
   localparam int unsigned CNT_W = 20;
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [15:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic valid;
      logic [15:0] rdata;
   } reg_rsp_t;
endpackage

// *** verilog/nvm_program_port.sv ***
// Programming port: control, word select and new value registers over a nonvolatile array.
// Assumes the I2C transport delivers one-cycle request pulses synchronous to clock.
`timescale 1ns/1ps
// What this block does
// - Store twenty-four sixteen-bit nonvolatile words
// - Control bits: voltage, clear, write, read
// - Select low five bits pick target word
// - New value register supplies stored data
// - Clear or write takes ten milliseconds
// - Read of word number returns contents
module nvm_program_port #(
   parameter int unsigned CELL_CYCLES_P = nvm_pkg::CELL_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   input wire nvm_pkg::reg_req_t req,
   output nvm_pkg::reg_rsp_t rsp,
   output logic busy
);
   typedef enum logic [1:0] {IDLE, PULSE, DONE} cell_state_t;
   cell_state_t state_q, state_d;
   logic [15:0] control_q, control_d;
   logic [15:0] select_q, select_d;
   logic [15:0] value_q, value_d;
   logic [nvm_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [4:0] target_q, target_d;
   logic clear_op_q, clear_op_d;
   logic [15:0] mem_q [nvm_pkg::WORDS];
   nvm_pkg::reg_rsp_t rsp_d;
   logic busy_d;
   logic clear_cell_select, write_sel, voltage_on, commit;
   logic [4:0] nvm_word_index;

   assign voltage_on = control_q[nvm_pkg::BIT_VOLTAGE];
   // Modes count only with the voltage on
   assign clear_cell_select = control_q[nvm_pkg::BIT_CLEAR] & voltage_on;
   assign write_sel = control_q[nvm_pkg::BIT_WRITE] & voltage_on;
   assign nvm_word_index = select_q[nvm_pkg::IDX_W-1:0];
   assign commit = (state_q == PULSE) && (cnt_q == nvm_pkg::CNT_W'(CELL_CYCLES_P - 1));

   // Register writes and the cell sequencer
   always_comb begin
      control_d = control_q;
      select_d = select_q;
      value_d = value_q;
      state_d = state_q;
      cnt_d = cnt_q;
      target_d = target_q;
      clear_op_d = clear_op_q;
      if (req.write) begin
         unique case (req.addr)
            nvm_pkg::OFF_CONTROL: control_d = req.wdata;
            nvm_pkg::OFF_SELECT: select_d = req.wdata;
            nvm_pkg::OFF_VALUE: value_d = req.wdata;
            default: ;
         endcase
      end
      unique case (state_q)
         IDLE: begin
            // Target is latched at start so later select writes cannot split the cell
            if (clear_cell_select || write_sel) begin
               state_d = PULSE;
               cnt_d = '0;
               target_d = nvm_word_index;
               clear_op_d = clear_cell_select;
            end
         end
         PULSE: begin
            // Dropping the voltage early aborts; the word is left unchanged
            if (!voltage_on) begin
               state_d = IDLE;
            end else if (commit) begin
               state_d = DONE;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         DONE: begin
            // Hold until the host drops the control word, so one pulse gives one commit
            if (!(clear_cell_select || write_sel)) begin
               state_d = IDLE;
            end
         end
      endcase
   end

   // Readback: control registers or stored word by number
   always_comb begin
      rsp_d.valid = req.read;
      rsp_d.rdata = 16'h0000;
      if (req.addr == nvm_pkg::OFF_CONTROL) begin
         rsp_d.rdata = control_q;
      end else if (req.addr == nvm_pkg::OFF_SELECT) begin
         rsp_d.rdata = select_q;
      end else if (req.addr == nvm_pkg::OFF_VALUE) begin
         rsp_d.rdata = value_q;
      end else if (req.addr < nvm_pkg::REG_ADDR_W'(nvm_pkg::WORDS)) begin
         rsp_d.rdata = mem_q[req.addr[4:0]];
      end
      busy_d = (state_d == PULSE);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= IDLE;
         control_q <= nvm_pkg::CONTROL_RESET;
         select_q <= nvm_pkg::SELECT_RESET;
         value_q <= nvm_pkg::VALUE_RESET;
         cnt_q <= '0;
         target_q <= '0;
         clear_op_q <= 1'b0;
         rsp <= '0;
         busy <= 1'b0;
      end else if (clock_en) begin
         state_q <= state_d;
         control_q <= control_d;
         select_q <= select_d;
         value_q <= value_d;
         cnt_q <= cnt_d;
         target_q <= target_d;
         clear_op_q <= clear_op_d;
         rsp <= rsp_d;
         busy <= busy_d;
      end
   end

   // Array cells; nonvolatile, so only the reset pattern stands for prior contents
   for (genvar w = 0; w < nvm_pkg::WORDS; w++) begin : g_word
      logic [15:0] word_d;
      always_comb begin
         word_d = mem_q[w];
         if (clock_en && commit && voltage_on && target_q == 5'(w)) begin
            // Erase sets all ones; write can only pull bits low, hence erase first
            word_d = clear_op_q ? nvm_pkg::WORD_RESET : (mem_q[w] & value_q);
         end
      end
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            mem_q[w] <= nvm_pkg::WORD_RESET;
         end else begin
            mem_q[w] <= word_d;
         end
      end
   end

   // Assertions
   sequence pulse_start_s;
      (state_q == IDLE) && (clear_cell_select || write_sel) && clock_en;
   endsequence

   mode_needs_volt_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == IDLE && !voltage_on && clock_en) |=> state_q == IDLE)
      else $error("cell started without voltage");
   pulse_enters_a: assert property (@(posedge clock) disable iff (!reset_n)
      pulse_start_s |=> state_q == PULSE && busy)
      else $error("pulse did not start");
   target_latched_a: assert property (@(posedge clock) disable iff (!reset_n)
      pulse_start_s |=> target_q == $past(nvm_word_index))
      else $error("target word not latched");
   target_stable_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == PULSE) |=> $stable(target_q))
      else $error("target changed mid pulse");
   // A pulse with the voltage held must run its full count before it may leave
   cell_time_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == PULSE && voltage_on && clock_en && !commit) |=> state_q == PULSE && busy)
      else $error("pulse ended before cell time");
   erase_ones_a: assert property (@(posedge clock) disable iff (!reset_n)
      (commit && clock_en && voltage_on && clear_op_q && target_q < 5'(nvm_pkg::WORDS))
      |=> mem_q[$past(target_q)] == 16'hFFFF)
      else $error("erase did not set word");
   write_value_a: assert property (@(posedge clock) disable iff (!reset_n)
      (commit && clock_en && voltage_on && !clear_op_q && target_q < 5'(nvm_pkg::WORDS)
      && mem_q[target_q] == 16'hFFFF)
      |=> mem_q[$past(target_q)] == $past(value_q))
      else $error("write did not store value");
   read_word_a: assert property (@(posedge clock) disable iff (!reset_n)
      (req.read && clock_en && req.addr == 8'h07 && state_q != PULSE)
      |=> rsp.valid && rsp.rdata == $past(mem_q[7]))
      else $error("word readback wrong");

   // Commit step of a cell operation
   sequence pulse_commit_s;
      commit && voltage_on && clock_en;
   endsequence

   // Commit ends the pulse and drops busy in the same step
   cell_done_a: assert property (@(posedge clock) disable iff (!reset_n)
      pulse_commit_s |=> state_q == DONE && !busy)
      else $error("commit did not end pulse");
   // Voltage removed mid pulse aborts without a commit
   abort_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == PULSE && !voltage_on && clock_en) |=> state_q == IDLE && !busy)
      else $error("voltage drop did not abort");
   // A held control word must not restart a second cell operation
   one_commit_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == DONE && (clear_cell_select || write_sel)) |=> state_q == DONE)
      else $error("second commit from one pulse");
   // Clock enable low freezes registers and answer
   freeze_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      !clock_en |=> $stable(control_q) && $stable(state_q) && $stable(rsp))
      else $error("state moved while frozen");
   // Register writes land on the next edge
   control_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      (req.write && clock_en && req.addr == nvm_pkg::OFF_CONTROL)
      |=> control_q == $past(req.wdata))
      else $error("control write lost");
   select_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      (req.write && clock_en && req.addr == nvm_pkg::OFF_SELECT)
      |=> select_q == $past(req.wdata))
      else $error("select write lost");
   value_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      (req.write && clock_en && req.addr == nvm_pkg::OFF_VALUE)
      |=> value_q == $past(req.wdata))
      else $error("new value write lost");
   // Numbers that map to nothing answer zero, so stale words never leak out
   unmapped_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
      (req.read && clock_en && req.addr >= nvm_pkg::REG_ADDR_W'(nvm_pkg::WORDS)
      && req.addr != nvm_pkg::OFF_CONTROL && req.addr != nvm_pkg::OFF_SELECT
      && req.addr != nvm_pkg::OFF_VALUE) |=> rsp.valid && rsp.rdata == 16'h0000)
      else $error("unmapped read not zero");
   // Outside a pulse word 7 may not change
   word_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q != PULSE) |=> $stable(mem_q[7]))
      else $error("word changed outside pulse");
endmodule

// *** bench/nvm_host_model.sv ***
// Host side model: issues register reads, writes and programming sequences.
// Assumes the port takes one-cycle request pulses on the rising edge of clock.
`timescale 1ns/1ps
module nvm_host_model (
   input wire logic clock,
   input wire logic busy,
   output nvm_pkg::reg_req_t req,
   input wire nvm_pkg::reg_rsp_t rsp
);
   // Idle bus until the bench asks for traffic
   initial req = '0;
   // One write pulse, launched on the falling edge and dropped one cycle later
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(negedge clock);
      req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
      @(negedge clock);
      req <= '0;
   endtask
   // Read with a bounded wait for the answer
   task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic ok);
      @(negedge clock);
      req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge clock);
      req <= '0;
      ok = 1'b0;
      v = 16'h0000;
      for (int i = 0; i < 3 && !ok; i++) begin
         if (rsp.valid === 1'b1) begin
            ok = 1'b1;
            v = rsp.rdata;
         end else begin
            @(negedge clock);
         end
      end
   endtask
   // Select, data, mode, hold the pulse 1.5 cell times, then drop voltage
   // Unused bits stay zero; one word at a time; callers clear before writing
   task automatic prog(input logic [4:0] w, input logic [15:0] v, input logic [15:0] ctl,
                       input int cells, output int n);
      n = 0;
      // Reserved factory words are never touched; no traffic at all
      if (w != 5'd0 && w != 5'd19) begin
         wr(8'hA2, {11'h000, w});
         wr(8'hA3, v);
         wr(8'hA1, ctl);
         repeat (cells * 3 / 2) begin
            @(negedge clock);
            if (busy === 1'b1) n++;
         end
         wr(8'hA1, 16'h0000);
      end
   endtask
endmodule

// *** bench/nvm_program_port_tb_top.sv ***
// Testbench for the programming port: register access and word programming.
// Assumes the host model drives all requests; cell time shortened to 20 cycles.
`timescale 1ns/1ps
module nvm_program_port_tb_top;
   localparam int CELLS = 20;
   logic clock, reset_n, clock_en, busy, ok;
   nvm_pkg::reg_req_t req;
   nvm_pkg::reg_rsp_t rsp;
   logic [15:0] d;
   int bad_count = 0;
   int check_count = 0;
   int n;
   nvm_program_port #(.CELL_CYCLES_P(CELLS)) uut (.clock(clock), .reset_n(reset_n),
      .clock_en(clock_en), .req(req), .rsp(rsp), .busy(busy));
   nvm_host_model host (.clock(clock), .busy(busy), .req(req), .rsp(rsp));
   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
      host.rd(a, d, ok);
      chk({what, " answer"}, {15'h0000, ok}, 16'h0001);
      chk(what, d, exp);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog so a stuck run still reaches the verdict
   initial begin
      repeat (5000) @(posedge clock);
      bad_count++;
      end_of_test;
   end
   // Main sequence
   initial begin
      clock_en = 1'b1;
      reset_n = 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock) reset_n = 1'b1;
      rdchk("control", 8'hA1, 16'h0000);
      rdchk("select", 8'hA2, 16'h0000);
      rdchk("word7", 8'h07, 16'hFFFF);
      rdchk("word23", 8'h17, 16'hFFFF);
      rdchk("unmapped", 8'h50, 16'h0000);
      host.wr(8'hA3, 16'hA55A);
      rdchk("value", 8'hA3, 16'hA55A);
      host.wr(8'hA1, 16'h0008);
      rdchk("readmode", 8'hA1, 16'h0008);
      chk("idle busy", {15'h0000, busy}, 16'h0000);
      $display("test registers done");
      host.prog(5'd7, 16'h0000, 16'h0003, CELLS, n);
      chk("clear time", (n >= 19 && n <= 21) ? 16'h0001 : 16'h0000, 16'h0001);
      rdchk("cleared", 8'h07, 16'hFFFF);
      host.prog(5'd7, 16'h0105, 16'h0005, CELLS, n);
      chk("write time", (n >= 19 && n <= 21) ? 16'h0001 : 16'h0000, 16'h0001);
      rdchk("written", 8'h07, 16'h0105);
      rdchk("neighbour", 8'h08, 16'hFFFF);
      rdchk("below", 8'h06, 16'hFFFF);
      $display("test program done");
      host.prog(5'd8, 16'h0000, 16'h0004, CELLS, n);
      chk("no pulse", n[15:0], 16'h0000);
      rdchk("unvolted", 8'h08, 16'hFFFF);
      host.wr(8'hA2, 16'h0008);
      host.wr(8'hA1, 16'h0005);
      host.wr(8'hA1, 16'h0000);
      rdchk("aborted", 8'h08, 16'hFFFF);
      chk("abort busy", {15'h0000, busy}, 16'h0000);
      host.prog(5'd7, 16'h0000, 16'h0002, CELLS, n);
      chk("no clear pulse", n[15:0], 16'h0000);
      rdchk("kept", 8'h07, 16'h0105);
      host.prog(5'd7, 16'h0000, 16'h0003, CELLS, n);
      rdchk("recleared", 8'h07, 16'hFFFF);
      host.prog(5'd23, 16'h0000, 16'h0003, CELLS, n);
      host.prog(5'd23, 16'h00A5, 16'h0005, CELLS, n);
      rdchk("top word", 8'h17, 16'h00A5);
      $display("test modes done");
      @(negedge clock) clock_en = 1'b0;
      host.wr(8'hA3, 16'h1234);
      clock_en = 1'b1;
      rdchk("frozen", 8'hA3, 16'h00A5);
      $display("test freeze done");
      @(negedge clock) reset_n = 1'b0;
      @(negedge clock) reset_n = 1'b1;
      rdchk("reset word", 8'h17, 16'hFFFF);
      rdchk("reset control", 8'hA1, 16'h0000);
      $display("test reset done");
      end_of_test;
   end
endmodule
